// ===== shared/mem_map_pkg.sv
package mem_map_pkg;

  // widths
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned PAGE_W      = 7;
  localparam int unsigned EXT_ADDR_W  = ADDR_W + PAGE_W;
  localparam int unsigned RAM_BLOCKS  = 4;
  localparam int unsigned RAM_IDX_W   = 13;
  localparam int unsigned ROM_IDX_W   = 14;
  localparam int unsigned VEC_NUM_W   = 5;
  localparam int unsigned VEC_PTR_W   = 9;

  // memory-mapped register in data space
  localparam logic [15:0] PAGE_SEL_OFFSET = 16'h001e;
  localparam logic [15:0] PAGE_SEL_RESET  = 16'h0000;

  // processor mode control field positions and reset values
  localparam int unsigned VEC_PTR_LSB    = 7;
  localparam int unsigned MC_FLAG_BIT    = 6;
  localparam int unsigned RAM_OVERLAY_FLAG_FLAG_BIT  = 5;
  localparam int unsigned AVIS_BIT       = 4;
  localparam int unsigned RSVD_BIT       = 3;
  localparam logic [8:0]  VEC_PTR_RESET  = 9'h1ff;
  localparam logic [15:0] MODE_LOW_MASK  = 16'h0037;
  localparam logic [15:0] MODE_LOW_RESET = 16'h0000;

  // address ranges
  localparam logic [15:0] RAM_LO         = 16'h0080;
  localparam logic [15:0] RAM_HI         = 16'h7fff;
  localparam logic [15:0] ROM_LO         = 16'hc000;
  localparam logic [15:0] BOOT_LO        = 16'hf800;
  localparam logic [15:0] BOOT_HI        = 16'hfbff;
  localparam logic [15:0] VEC_TBL_LO     = 16'hff80;
  localparam logic [15:0] HOST_PROT_LO   = 16'h4000;
  localparam logic [15:0] HOST_PROT_HI   = 16'h5fff;
  localparam logic [15:0] RESET_VEC_ADDR = 16'hff80;
  localparam int unsigned VEC_SPACING_SH = 2;
  localparam int unsigned VEC_PAGE_SH    = 7;

  typedef struct packed {
    logic              valid;
    logic              wr;
    logic [15:0]       addr;
    logic [15:0]       wdata;
  } mem_req_t;

  typedef struct packed {
    logic              valid;
    logic              ext;
    logic              rom;
    logic [3:0]        ram;
    logic [13:0]       index;
    logic [22:0]       ext_addr;
  } mem_sel_t;

  typedef struct packed {
    logic              valid;
    logic [4:0]        num;
  } vec_req_t;

  typedef struct packed {
    logic              valid;
    logic [15:0]       pc;
  } vec_out_t;

endpackage : mem_map_pkg

// ===== logic/region_decode.sv
`timescale 1ns/100ps
module region_decode (
  // request
  input  wire logic [15:0]         i_addr,
  input  wire logic [6:0]          i_page,
  input  wire logic                i_prog_space,
  // mapping state
  input  wire logic                i_ram_overlay_flag,
  input  wire logic                i_rom_en,
  // result
  output mem_map_pkg::mem_sel_t    o_sel
);
  import mem_map_pkg::*;

  logic in_ram;
  logic in_rom;
  logic ram_ok;
  logic rom_ok;

  always_comb begin
    in_ram = (i_addr >= RAM_LO) && (i_addr <= RAM_HI);
    in_rom = (i_addr >= ROM_LO);
    // page 0 of data never reaches program space since RAM_LO excludes it
    ram_ok = in_ram && (!i_prog_space || i_ram_overlay_flag);
    // rom never answers in data space; in program space only page 0 and while enabled
    rom_ok = in_rom && i_prog_space && i_rom_en && (i_page == 7'h00);
    o_sel.valid    = 1'b1;
    o_sel.rom      = rom_ok;
    o_sel.ram      = 4'h0;
    if (ram_ok) begin
      o_sel.ram[i_addr[14:13]] = 1'b1;
    end
    o_sel.ext      = !ram_ok && !rom_ok;
    o_sel.index    = rom_ok ? i_addr[13:0] : {1'b0, i_addr[12:0]};
    o_sel.ext_addr = i_prog_space ? {i_page, i_addr} : {7'h00, i_addr};
  end

endmodule : region_decode

// ===== logic/mem_map_ctrl.sv
`timescale 1ns/100ps
module mem_map_ctrl #(
  parameter int unsigned PAGE_BITS = 7
) (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_sys_rst,
  // device pins and options
  input  wire logic                   i_mc_mode_pin,
  input  wire logic                   i_protect_opt,
  // core: soft reset and mode register write port
  input  wire logic                   i_soft_rst,
  input  wire logic                   i_mode_wr,
  input  wire logic [15:0]            i_mode_wdata,
  // core: program fetch and two data ports
  input  wire mem_map_pkg::mem_req_t  i_prog_req,
  input  wire mem_map_pkg::mem_req_t  i_data_rd_req,
  input  wire mem_map_pkg::mem_req_t  i_data_rw_req,
  // core: vector request
  input  wire mem_map_pkg::vec_req_t  i_vec_req,
  // host port and outside instruction access
  input  wire mem_map_pkg::mem_req_t  i_host_req,
  input  wire logic                   i_ext_instr_req,
  // decode results
  output mem_map_pkg::mem_sel_t       o_prog_sel,
  output mem_map_pkg::mem_sel_t       o_data_rd_sel,
  output mem_map_pkg::mem_sel_t       o_data_rw_sel,
  output mem_map_pkg::mem_sel_t       o_host_sel,
  output logic                        o_host_denied,
  output logic                        o_ext_instr_grant,
  output logic                        o_ext_instr_denied,
  // vectors
  output mem_map_pkg::vec_out_t       o_vec,
  // register views
  output logic [15:0]                 o_mode,
  output logic [15:0]                 o_page_sel,
  output logic [15:0]                 o_mmr_rdata,
  output logic                        o_mmr_rvalid
);
  import mem_map_pkg::*;

  if (PAGE_BITS < 1 || PAGE_BITS > PAGE_W) begin : g_bad_page
    $error("PAGE_BITS must lie between 1 and 7");
  end

  // pin synchronisers; not reset so that the pin level reaches the flag during reset
  logic       mc_meta_r;
  logic       mc_sync_r;
  logic       prot_meta_r;
  logic       prot_sync_r;

  always_ff @(posedge i_mclk) begin
    mc_meta_r   <= i_mc_mode_pin;
    mc_sync_r   <= mc_meta_r;
    prot_meta_r <= i_protect_opt;
    prot_sync_r <= prot_meta_r;
  end

  // mode and page registers
  logic [8:0]  vec_ptr_r;
  logic [8:0]  vec_ptr_nxt;
  logic        mc_flag_r;
  logic        mc_flag_nxt;
  logic        ram_overlay_flag_r;
  logic        ram_overlay_flag_nxt;
  logic [4:0]  mode_low_r;
  logic [4:0]  mode_low_nxt;
  logic [6:0]  page_r;
  logic [6:0]  page_nxt;
  logic        page_wr;

  always_comb begin
    vec_ptr_nxt  = vec_ptr_r;
    mc_flag_nxt  = mc_flag_r;
    ram_overlay_flag_nxt     = ram_overlay_flag_r;
    mode_low_nxt = mode_low_r;
    page_nxt     = page_r;
    page_wr      = i_data_rw_req.valid && i_data_rw_req.wr && (i_data_rw_req.addr == PAGE_SEL_OFFSET);
    if (i_sys_rst) begin
      vec_ptr_nxt  = VEC_PTR_RESET;
      mc_flag_nxt  = mc_sync_r;
      ram_overlay_flag_nxt     = 1'b0;
      mode_low_nxt = MODE_LOW_RESET[4:0];
      page_nxt     = PAGE_SEL_RESET[6:0];
    end else begin
      // software reset leaves pointer and mode flag alone
      if (i_mode_wr) begin
        vec_ptr_nxt  = i_mode_wdata[15:VEC_PTR_LSB];
        mc_flag_nxt  = i_mode_wdata[MC_FLAG_BIT];
        ram_overlay_flag_nxt     = i_mode_wdata[RAM_OVERLAY_FLAG_FLAG_BIT];
        mode_low_nxt = i_mode_wdata[4:0] & MODE_LOW_MASK[4:0];
      end
      if (page_wr) begin
        // upper page bits beyond PAGE_BITS are held at zero
        page_nxt = i_data_rw_req.wdata[6:0] & 7'((1 << PAGE_BITS) - 1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    vec_ptr_r  <= vec_ptr_nxt;
    mc_flag_r  <= mc_flag_nxt;
    ram_overlay_flag_r     <= ram_overlay_flag_nxt;
    mode_low_r <= mode_low_nxt;
    page_r     <= page_nxt;
  end

  // decoders
  mem_sel_t prog_dec;
  mem_sel_t rd_dec;
  mem_sel_t rw_dec;
  mem_sel_t host_dec;

  region_decode u_prog_dec (
    .i_addr       (i_prog_req.addr),
    .i_page       (page_r),
    .i_prog_space (1'b1),
    .i_ram_overlay_flag       (ram_overlay_flag_r),
    .i_rom_en     (!mc_flag_r),
    .o_sel        (prog_dec)
  );

  region_decode u_rd_dec (
    .i_addr       (i_data_rd_req.addr),
    .i_page       (7'h00),
    .i_prog_space (1'b0),
    .i_ram_overlay_flag       (ram_overlay_flag_r),
    .i_rom_en     (1'b0),
    .o_sel        (rd_dec)
  );

  region_decode u_rw_dec (
    .i_addr       (i_data_rw_req.addr),
    .i_page       (7'h00),
    .i_prog_space (1'b0),
    .i_ram_overlay_flag       (ram_overlay_flag_r),
    .i_rom_en     (1'b0),
    .o_sel        (rw_dec)
  );

  region_decode u_host_dec (
    .i_addr       (i_host_req.addr),
    .i_page       (7'h00),
    .i_prog_space (1'b0),
    .i_ram_overlay_flag       (ram_overlay_flag_r),
    .i_rom_en     (1'b0),
    .o_sel        (host_dec)
  );

  // registered decode results, vectors and access checks
  mem_sel_t    prog_sel_r;
  mem_sel_t    prog_sel_nxt;
  mem_sel_t    rd_sel_r;
  mem_sel_t    rd_sel_nxt;
  mem_sel_t    rw_sel_r;
  mem_sel_t    rw_sel_nxt;
  mem_sel_t    host_sel_r;
  mem_sel_t    host_sel_nxt;
  logic        host_denied_r;
  logic        host_denied_nxt;
  logic        xi_grant_r;
  logic        xi_grant_nxt;
  logic        xi_denied_r;
  logic        xi_denied_nxt;
  vec_out_t    vec_r;
  vec_out_t    vec_nxt;
  logic        boot_pend_r;
  logic        boot_pend_nxt;
  logic [15:0] mmr_rdata_r;
  logic [15:0] mmr_rdata_nxt;
  logic        mmr_rvalid_r;
  logic        mmr_rvalid_nxt;
  logic        host_in_window;

  always_comb begin
    prog_sel_nxt       = prog_dec;
    prog_sel_nxt.valid = i_prog_req.valid;
    rd_sel_nxt         = rd_dec;
    rd_sel_nxt.valid   = i_data_rd_req.valid;
    rw_sel_nxt         = rw_dec;
    rw_sel_nxt.valid   = i_data_rw_req.valid;
    host_in_window     = (i_host_req.addr >= HOST_PROT_LO) && (i_host_req.addr <= HOST_PROT_HI);
    host_denied_nxt    = i_host_req.valid && !i_host_req.wr && prot_sync_r && !host_in_window;
    host_sel_nxt       = host_dec;
    host_sel_nxt.valid = i_host_req.valid && !host_denied_nxt;
    xi_grant_nxt       = i_ext_instr_req && !prot_sync_r;
    xi_denied_nxt      = i_ext_instr_req && prot_sync_r;
    mmr_rvalid_nxt     = i_data_rd_req.valid && !i_data_rd_req.wr && (i_data_rd_req.addr == PAGE_SEL_OFFSET);
    mmr_rdata_nxt      = mmr_rvalid_nxt ? {9'h000, page_r} : 16'h0000;
    boot_pend_nxt      = 1'b0;
    vec_nxt.valid      = 1'b0;
    vec_nxt.pc         = vec_r.pc;
    if (i_sys_rst) begin
      boot_pend_nxt = 1'b1;
      vec_nxt.pc    = RESET_VEC_ADDR;
    end else if (boot_pend_r) begin
      // first fetch after hardware reset: fixed address, rom if mode pin was low
      vec_nxt.valid = 1'b1;
      vec_nxt.pc    = RESET_VEC_ADDR;
    end else if (i_soft_rst) begin
      // software reset vectors through the current pointer page
      vec_nxt.valid = 1'b1;
      vec_nxt.pc    = 16'(vec_ptr_r) << VEC_PAGE_SH;
    end else if (i_vec_req.valid) begin
      vec_nxt.valid = 1'b1;
      vec_nxt.pc    = (16'(vec_ptr_r) << VEC_PAGE_SH)
                    | (16'(i_vec_req.num) << VEC_SPACING_SH);
    end
    if (i_sys_rst) begin
      prog_sel_nxt.valid = 1'b0;
      rd_sel_nxt.valid   = 1'b0;
      rw_sel_nxt.valid   = 1'b0;
      host_sel_nxt.valid = 1'b0;
      host_denied_nxt    = 1'b0;
      xi_grant_nxt       = 1'b0;
      xi_denied_nxt      = 1'b0;
      mmr_rvalid_nxt     = 1'b0;
      mmr_rdata_nxt      = 16'h0000;
    end
  end

  always_ff @(posedge i_mclk) begin
    prog_sel_r    <= prog_sel_nxt;
    rd_sel_r      <= rd_sel_nxt;
    rw_sel_r      <= rw_sel_nxt;
    host_sel_r    <= host_sel_nxt;
    host_denied_r <= host_denied_nxt;
    xi_grant_r    <= xi_grant_nxt;
    xi_denied_r   <= xi_denied_nxt;
    vec_r         <= vec_nxt;
    boot_pend_r   <= boot_pend_nxt;
    mmr_rdata_r   <= mmr_rdata_nxt;
    mmr_rvalid_r  <= mmr_rvalid_nxt;
  end

  assign o_prog_sel         = prog_sel_r;
  assign o_data_rd_sel      = rd_sel_r;
  assign o_data_rw_sel      = rw_sel_r;
  assign o_host_sel         = host_sel_r;
  assign o_host_denied      = host_denied_r;
  assign o_ext_instr_grant  = xi_grant_r;
  assign o_ext_instr_denied = xi_denied_r;
  assign o_vec              = vec_r;
  assign o_mode             = {vec_ptr_r, mc_flag_r, ram_overlay_flag_r, mode_low_r};
  assign o_page_sel         = {9'h000, page_r};
  assign o_mmr_rdata        = mmr_rdata_r;
  assign o_mmr_rvalid       = mmr_rvalid_r;

endmodule : mem_map_ctrl

// ===== verif/mem_map_ctrl_props.sv
`timescale 1ns/100ps
module mem_map_ctrl_props #(
  parameter int unsigned PAGE_BITS = 7
) (
  // clock and reset
  input wire logic                  i_mclk,
  input wire logic                  i_sys_rst,
  // requests
  input wire logic                  i_protect_opt,
  input wire logic                  i_soft_rst,
  input wire mem_map_pkg::mem_req_t i_prog_req,
  input wire mem_map_pkg::mem_req_t i_data_rd_req,
  input wire mem_map_pkg::mem_req_t i_host_req,
  input wire mem_map_pkg::vec_req_t i_vec_req,
  // answers
  input wire mem_map_pkg::mem_sel_t o_prog_sel,
  input wire mem_map_pkg::mem_sel_t o_data_rd_sel,
  input wire logic                  o_host_denied,
  input wire mem_map_pkg::vec_out_t o_vec,
  input wire logic [15:0]           o_mode,
  input wire logic [15:0]           o_page_sel
);
  import mem_map_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire logic       rd_ram = i_data_rd_req.addr >= RAM_LO && i_data_rd_req.addr <= RAM_HI;
  wire logic [6:0] pg     = o_page_sel[6:0] & 7'((1 << PAGE_BITS) - 1);
  a_data_ram_block: assert property (
    i_data_rd_req.valid && rd_ram |=> !o_data_rd_sel.ext
      && o_data_rd_sel.ram == (4'h1 << $past(i_data_rd_req.addr[14:13])))
    else $error("data ram block wrong");
  a_data_goes_ext: assert property (
    i_data_rd_req.valid && !rd_ram |=> o_data_rd_sel.ext && !o_data_rd_sel.rom && o_data_rd_sel.ram == 4'h0
      && o_data_rd_sel.ext_addr == {7'h0, $past(i_data_rd_req.addr)})
    else $error("data access not external");
  a_prog_ext_addr: assert property (
    i_prog_req.valid |=> o_prog_sel.valid && o_prog_sel.ext_addr == {$past(pg), $past(i_prog_req.addr)})
    else $error("program address wrong");
  a_rom_in_page0: assert property (
    i_prog_req.valid && i_prog_req.addr >= ROM_LO && pg == 7'h0 |=> o_prog_sel.rom == !$past(o_mode[MC_FLAG_BIT]))
    else $error("rom decode wrong");
  a_ram_overlay_flag_ram_gate: assert property (
    i_prog_req.valid && (i_prog_req.addr < RAM_LO || !o_mode[RAM_OVERLAY_FLAG_FLAG_BIT]) |=> o_prog_sel.ram == 4'h0)
    else $error("ram seen in program space");
  a_host_read_limit: assert property (
    i_protect_opt [*3] ##0 (i_host_req.valid && !i_host_req.wr
      && (i_host_req.addr < HOST_PROT_LO || i_host_req.addr > HOST_PROT_HI)) |=> o_host_denied)
    else $error("host read not refused");
  a_vec_location: assert property (
    i_vec_req.valid && !i_soft_rst && !$past(i_sys_rst) |=> o_vec.valid
      && o_vec.pc == {$past(o_mode[15:7]), $past(i_vec_req.num), 2'b00})
    else $error("vector address wrong");
  a_boot_vector: assert property (
    $fell(i_sys_rst) |-> ##[1:2] (o_vec.valid && o_vec.pc == RESET_VEC_ADDR))
    else $error("boot vector missing");
endmodule : mem_map_ctrl_props
bind mem_map_ctrl mem_map_ctrl_props #(.PAGE_BITS(PAGE_BITS)) i_mem_map_ctrl_props (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_protect_opt(i_protect_opt), .i_soft_rst(i_soft_rst),
  .i_prog_req(i_prog_req), .i_data_rd_req(i_data_rd_req), .i_host_req(i_host_req), .i_vec_req(i_vec_req),
  .o_prog_sel(o_prog_sel), .o_data_rd_sel(o_data_rd_sel), .o_host_denied(o_host_denied),
  .o_vec(o_vec), .o_mode(o_mode), .o_page_sel(o_page_sel));

// ===== verif/core_agent.sv
`timescale 1ns/100ps
module core_agent (
  // clock
  input  wire logic                   i_mclk,
  // program, data read, data read/write, host
  output mem_map_pkg::mem_req_t [3:0] o_req
);
  import mem_map_pkg::*;
  mem_req_t [3:0] pend = '0;
  initial o_req = '0;
  // an idle port shows the inverse of its last address, so a stale value is never mistaken for a live one
  always @(posedge i_mclk) begin
    for (int p = 0; p < 4; p++) begin
      o_req[p] <= pend[p].valid ? pend[p] : mem_req_t'{1'b0, 1'b0, ~o_req[p].addr, ~o_req[p].wdata};
      pend[p].valid = 1'b0;
    end
  end
  task automatic put(input int p, input mem_req_t r);
    pend[p] = r;
  endtask : put
endmodule : core_agent

// ===== verif/mem_map_ctrl_test.sv
`timescale 1ns/100ps
module mem_map_ctrl_test;
  import mem_map_pkg::*;
  logic           i_mclk, i_sys_rst, i_mc_mode_pin, i_protect_opt, i_soft_rst, i_mode_wr, i_ext_instr_req;
  logic           deny, grant, refuse, rv;
  logic [15:0]    i_mode_wdata, o_mode, o_page_sel, rdata, a, m;
  vec_req_t       i_vec_req;
  vec_out_t       o_vec;
  mem_req_t [3:0] rq;
  mem_sel_t [3:0] sel;
  mem_sel_t       e, t;
  logic [6:0]     pg;
  int             n_mismatch, samples_checked, seed, k;
  logic [15:0]    corner [12] = '{16'h007f, 16'h0080, 16'h1fff, 16'h2000, 16'h4000, 16'h5fff,
                                  16'h6000, 16'h7fff, 16'h8000, 16'hc000, 16'hf800, 16'hffff};
  core_agent i_core_agent (.i_mclk(i_mclk), .o_req(rq));
  mem_map_ctrl i_mem_map_ctrl (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_mc_mode_pin(i_mc_mode_pin),
    .i_protect_opt(i_protect_opt), .i_soft_rst(i_soft_rst), .i_mode_wr(i_mode_wr), .i_mode_wdata(i_mode_wdata),
    .i_prog_req(rq[0]), .i_data_rd_req(rq[1]), .i_data_rw_req(rq[2]), .i_host_req(rq[3]), .i_vec_req(i_vec_req),
    .i_ext_instr_req(i_ext_instr_req), .o_prog_sel(sel[0]), .o_data_rd_sel(sel[1]), .o_data_rw_sel(sel[2]),
    .o_host_sel(sel[3]), .o_host_denied(deny), .o_ext_instr_grant(grant), .o_ext_instr_denied(refuse),
    .o_vec(o_vec), .o_mode(o_mode), .o_page_sel(o_page_sel), .o_mmr_rdata(rdata), .o_mmr_rvalid(rv));
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic req(input int p, input logic w, input logic [15:0] ad, wd);
    @(negedge i_mclk);
    i_core_agent.put(p, '{1'b1, w, ad, wd});
    repeat (2) @(negedge i_mclk);
  endtask : req
  function automatic mem_sel_t exp_sel(input logic prg, input logic [15:0] ad);
    mem_sel_t s;
    s = '0;
    s.valid = 1'b1;
    s.ext_addr = {prg ? pg : 7'h0, ad};
    if (ad >= 16'h0080 && ad <= 16'h7fff && (!prg || m[5])) begin
      s.ram = 4'h1 << ad[14:13];
      s.index = {1'b0, ad[12:0]};
    end else if (prg && ad >= 16'hc000 && !m[6] && pg == 7'h0) begin
      s.rom = 1'b1;
      s.index = ad[13:0];
    end else s.ext = 1'b1;
    return s;
  endfunction : exp_sel
  task automatic wr_mode(input logic [15:0] v);
    @(posedge i_mclk);
    i_mode_wr <= 1'b1;
    i_mode_wdata <= v;
    @(posedge i_mclk);
    i_mode_wr <= 1'b0;
    i_mode_wdata <= ~v;
    m = (v & 16'hffc0) | (v & MODE_LOW_MASK);
    @(negedge i_mclk);
    chk("mode", o_mode, m);
  endtask : wr_mode
  task automatic take_vec(input logic sr, input logic [4:0] n);
    @(posedge i_mclk);
    i_soft_rst <= sr;
    i_vec_req <= '{~sr, n};
    @(posedge i_mclk);
    i_soft_rst <= 1'b0;
    i_vec_req <= '{1'b0, ~n};
    @(negedge i_mclk);
    chk("vector", {o_vec.valid, o_vec.pc}, {1'b1, m[15:7], sr ? 7'h0 : {n, 2'b00}});
    chk("mode kept", o_mode, m);
  endtask : take_vec
  task automatic do_reset(input logic pin);
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    i_mc_mode_pin <= pin;
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(negedge i_mclk);
    for (k = 0; k < 4 && o_vec.valid !== 1'b1; k++) @(negedge i_mclk);
    if (k == 4) begin
      n_mismatch++;
      tally_and_finish();
    end
    m = {9'h1ff, pin, 6'h0};
    pg = 7'h0;
    chk("boot", {o_vec.pc, o_mode, o_page_sel}, {RESET_VEC_ADDR, m, PAGE_SEL_RESET});
    @(posedge i_mclk);
    i_mc_mode_pin <= ~pin;
    repeat (4) @(negedge i_mclk);
    chk("pin ignored", o_mode, m);
    $display("reset with mode pin %0d done", pin);
  endtask : do_reset
  initial begin
    seed = 64;
    n_mismatch = 0;
    samples_checked = 0;
    {i_sys_rst, i_mc_mode_pin, i_protect_opt, i_soft_rst, i_mode_wr, i_ext_instr_req} = 6'h30;
    i_mode_wdata = 16'h0;
    i_vec_req = '0;
    do_reset(1'b1);
    for (int c = 0; c < 4; c++) begin
      wr_mode(16'($random(seed)) & 16'hff9f | 16'(c << 5));
      pg = c[0] ? 7'($random(seed)) : 7'h0;
      req(2, 1'b1, PAGE_SEL_OFFSET, {9'($random(seed)), pg});
      chk("page", o_page_sel, {9'h0, pg});
      req(1, 1'b0, PAGE_SEL_OFFSET, 16'h0);
      chk("page read", {rv, rdata}, {1'b1, 9'h0, pg});
      for (int i = 0; i < 24; i++) begin
        a = i < 12 ? corner[i] : 16'($random(seed));
        req(i % 4, 1'b0, a, 16'($random(seed)));
        e = exp_sel(i % 4 == 0, a);
        t = sel[i % 4];
        if (e.ext) t.index = e.index;
        chk("decode", t, e);
      end
      $display("decode pass %0d done", c);
    end
    for (int pr = 0; pr < 2; pr++) begin
      @(posedge i_mclk);
      i_protect_opt <= pr[0];
      repeat (3) @(posedge i_mclk);
      for (int i = 2; i < 8; i++) begin
        req(3, 1'b0, corner[i], 16'h0);
        e.valid = pr[0] && (corner[i] < 16'h4000 || corner[i] > 16'h5fff);
        chk("host read", {deny, sel[3].valid}, {e.valid, ~e.valid});
      end
      req(3, 1'b1, 16'h0080, 16'($random(seed)));
      chk("host write", {deny, sel[3].valid}, 2'b01);
      @(posedge i_mclk);
      i_ext_instr_req <= 1'b1;
      @(posedge i_mclk);
      i_ext_instr_req <= 1'b0;
      @(negedge i_mclk);
      chk("outside fetch", {grant, refuse}, {~pr[0], pr[0]});
    end
    $display("protection done");
    for (int i = 0; i < 8; i++) begin
      if (i % 3 == 0) wr_mode(16'($random(seed)));
      take_vec(i[0], i < 2 ? 5'h1f : 5'($random(seed)));
    end
    $display("vectors done");
    do_reset(1'b0);
    req(0, 1'b0, 16'hff80, 16'h0);
    chk("boot fetch", sel[0], exp_sel(1'b1, 16'hff80));
    tally_and_finish();
  end
endmodule : mem_map_ctrl_test
